//--- core/ptt_periodic_tick_unit.sv
// periodic tick timer with an axi4-lite register slave
// Functional notes
// RULE_01: counter free-runs through wrap to zero
// RULE_02: enabling resumes from current count value
// RULE_03: count advances once per prescaler tick
// RULE_04: wrap ff to 00 sets wrap_flag
// RULE_05: software count writes accepted any time
// RULE_06: count readable, writable, increments when enabled
// RULE_07: cpu mask gating is outside block
// RULE_08: wrap_flag hardware-set, cleared by control read
// RULE_09: writes never change wrap_flag
// RULE_10: wrap_irq_enable rw; request while flag set
// RULE_11: count_enable low freezes counter, resets prescaler
// RULE_12: prescale factor is two to select+1
// RULE_13: control bits 7:6 read zero
// RULE_14: reset clears count and control
// RULE_15: runs in wait, stops in halt
// RULE_16: request is wrap_flag and wrap_irq_enable
`timescale 1ns/10ps
`include "ptt_map.svh"
module ptt_periodic_tick_unit #(
  parameter int ADDR_W = 12
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   wrap_irq,
  output logic                   irq
);

  // offsets are compared as 12-bit words, so wider buses are not served
  if (ADDR_W < 5 || ADDR_W > 12) begin : g_bad_addr_w
    $error("ADDR_W must lie between 5 and 12");
  end

  logic [7:0]        count_value_field;
  logic [7:0]        prescale_cnt;
  logic              count_enable;
  logic              wrap_irq_enable;
  logic [2:0]        prescale_select;
  logic              wrap_flag;
  logic              irq_stat;
  logic              irq_mask;
  ptt_pkg::ptt_power_t power_mode;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  logic              do_read;
  logic              tick;
  logic              wrap;
  logic              running;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PTT_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr, `PTT_OFS_COUNT) || hit(aw_addr, `PTT_OFS_CTRL)
          || hit(aw_addr, `PTT_OFS_IRQ_STAT) || hit(aw_addr, `PTT_OFS_IRQ_MASK)
          || hit(aw_addr, `PTT_OFS_POWER)) begin
        s_axi_bresp <= `PTT_RESP_OKAY;
      end else begin
        s_axi_bresp <= `PTT_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one read at a time, answer one cycle after address
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PTT_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PTT_RESP_OKAY;
      if (hit(s_axi_araddr, `PTT_OFS_COUNT)) begin
        s_axi_rdata <= {24'h00_0000, count_value_field}; // [RULE_06]
      end else if (hit(s_axi_araddr, `PTT_OFS_CTRL)) begin
        // bits 7:6 forced to zero [RULE_13]
        s_axi_rdata <= {26'h000_0000, wrap_flag, wrap_irq_enable, count_enable,
                        prescale_select};
      end else if (hit(s_axi_araddr, `PTT_OFS_IRQ_STAT)) begin
        s_axi_rdata <= {31'h0000_0000, irq_stat};
      end else if (hit(s_axi_araddr, `PTT_OFS_IRQ_MASK)) begin
        s_axi_rdata <= {31'h0000_0000, irq_mask};
      end else if (hit(s_axi_araddr, `PTT_OFS_POWER)) begin
        s_axi_rdata <= {30'h0000_0000, power_mode};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `PTT_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // control fields; wrap_flag position not writable [RULE_09] [RULE_13]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_enable    <= 1'b0; // [RULE_14]
      wrap_irq_enable <= 1'b0;
      prescale_select <= 3'h0;
    end else if (do_write && hit(aw_addr, `PTT_OFS_CTRL) && w_strb[0]) begin
      count_enable    <= w_data[`PTT_BIT_CNT_EN]; // [RULE_11]
      wrap_irq_enable <= w_data[`PTT_BIT_IRQ_EN]; // [RULE_10]
      prescale_select <= w_data[2:0]; // [RULE_12]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_mode <= ptt_pkg::PTT_PWR_RUN;
    end else if (do_write && hit(aw_addr, `PTT_OFS_POWER) && w_strb[0]) begin
      case (w_data[1:0])
        2'h1:    power_mode <= ptt_pkg::PTT_PWR_WAIT;
        2'h2:    power_mode <= ptt_pkg::PTT_PWR_HALT;
        default: power_mode <= ptt_pkg::PTT_PWR_RUN;
      endcase
    end
  end

  // halt stops the time base, wait does not [RULE_15]
  assign running = count_enable && (power_mode != ptt_pkg::PTT_PWR_HALT);

  // prescaler held at zero while disabled [RULE_11]
  always_ff @(posedge aclk) begin
    if (!aresetn || !count_enable) begin
      prescale_cnt <= 8'h00;
    end else if (running) begin
      prescale_cnt <= prescale_cnt + 8'h01;
    end
  end

  // tick once every 2^(select+1) clocks: low bits all ones [RULE_12] [RULE_03]
  always_comb begin
    tick = running;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(prescale_select) && !prescale_cnt[i]) begin
        tick = 1'b0;
      end
    end
  end

  assign wrap = tick && (count_value_field == 8'hFF);

  // software write wins over a tick; no reload on wrap [RULE_05] [RULE_01] [RULE_02]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_value_field <= `PTT_COUNT_RESET; // [RULE_14]
    end else if (do_write && hit(aw_addr, `PTT_OFS_COUNT) && w_strb[0]) begin
      count_value_field <= w_data[7:0]; // [RULE_05]
    end else if (tick) begin
      count_value_field <= count_value_field + 8'h01; // [RULE_03] [RULE_06]
    end
  end

  // set wins over read-clear so no wrap is lost [RULE_04] [RULE_08]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_flag <= 1'b0;
    end else if (wrap) begin
      wrap_flag <= 1'b1; // [RULE_04]
    end else if (do_read && hit(s_axi_araddr, `PTT_OFS_CTRL)) begin
      wrap_flag <= 1'b0; // [RULE_08]
    end
  end

  // sticky status for the bus interrupt, write one to clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= 1'b0;
    end else if (wrap) begin
      irq_stat <= 1'b1;
    end else if (do_write && hit(aw_addr, `PTT_OFS_IRQ_STAT) && w_strb[0] && w_data[0]) begin
      irq_stat <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= 1'b0;
    end else if (do_write && hit(aw_addr, `PTT_OFS_IRQ_MASK) && w_strb[0]) begin
      irq_mask <= w_data[0];
    end
  end

  // cpu global mask applied outside this block [RULE_16] [RULE_07] [RULE_10]
  assign wrap_irq = wrap_flag && wrap_irq_enable;
  assign irq      = irq_stat && irq_mask;

endmodule

//--- core/ptt_map.svh
// register offsets, field positions and reset values of the periodic tick timer
`ifndef PTT_MAP_SVH
`define PTT_MAP_SVH
`define PTT_OFS_COUNT      12'h000
`define PTT_OFS_CTRL       12'h004
`define PTT_OFS_IRQ_STAT   12'h008
`define PTT_OFS_IRQ_MASK   12'h00C
`define PTT_OFS_POWER      12'h010
`define PTT_BIT_WRAP       5
`define PTT_BIT_IRQ_EN     4
`define PTT_BIT_CNT_EN     3
`define PTT_CTRL_WR_MASK   8'h1F
`define PTT_COUNT_RESET    8'h00
`define PTT_CTRL_RESET     8'h00
`define PTT_RESP_OKAY      2'h0
`define PTT_RESP_SLVERR    2'h2
`endif

//--- core/ptt_pkg.sv
// types shared by the periodic tick timer
package ptt_pkg;
  typedef enum logic [1:0] {
    PTT_PWR_RUN  = 2'h0,
    PTT_PWR_WAIT = 2'h1,
    PTT_PWR_HALT = 2'h2
  } ptt_power_t;
endpackage

//--- verification/ptt_periodic_tick_unit_properties.sv
// bus and interrupt assertions for the periodic tick unit
`timescale 1ns/10ps
module ptt_periodic_tick_unit_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        wrap_irq,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ar_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid kept after handshake");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  // wrap request only falls on a control read or a write landing
  flag_keep_a: assert property (wrap_irq && !(s_axi_arvalid && s_axi_arready) |=> wrap_irq || $rose(s_axi_bvalid))
    else $error("wrap request lost without cause");
  irq_keep_a: assert property (irq |=> irq || $rose(s_axi_bvalid))
    else $error("interrupt lost without write");
  reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !wrap_irq && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
endmodule
bind ptt_periodic_tick_unit ptt_periodic_tick_unit_properties i_ptt_props (.*);

//--- verification/test_periodic_tick_timer.sv
// self-checking bench for the periodic tick unit
`timescale 1ns/10ps
module test_periodic_tick_timer;
  logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic wrap_irq, irq, m_flag, m_stat, m_mask, pend;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0, pa;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, exp_rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, m_pwr;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  m_cnt, pd;
  logic [4:0]  m_ctrl;
  int          m_pre, err_count = 0, tests_run = 0, cyc = 0;
  ptt_periodic_tick_unit i_ptt_periodic_tick_unit (.*);
  always #12.5 aclk = ~aclk;
  task automatic summarize();
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] rm(logic [11:0] a);
    case (a)
      12'h000: return {24'h0, m_cnt};
      12'h004: return {26'h0, m_flag, m_ctrl};
      12'h008: return {31'h0, m_stat};
      12'h00C: return {31'h0, m_mask};
      12'h010: return {30'h0, m_pwr};
      default: return 32'h0;
    endcase
  endfunction
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  // reference model, updated from pre-edge values like the registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      {m_cnt, m_ctrl, m_flag, m_stat, m_mask, m_pwr, pend} = 19'h0;
      m_pre = 0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        exp_rd = rm(s_axi_araddr);
        if (s_axi_araddr == 12'h004) m_flag = 1'h0;
      end
      if (!m_ctrl[3]) m_pre = 0;
      else if (m_pwr != 2'h2) begin
        m_pre++;
        if (m_pre == 2 << m_ctrl[2:0]) begin
          m_pre = 0;
          m_cnt++;
          if (m_cnt == 8'h00) {m_flag, m_stat} = 2'h3;
        end
      end
      // write applied after the tick so a count write wins
      if (pend)
        case (pa)
          12'h000: m_cnt = pd;
          12'h004: m_ctrl = pd[4:0];
          12'h008: m_stat &= ~pd[0];
          12'h00C: m_mask = pd[0];
          12'h010: m_pwr = (pd[1:0] == 2'h3) ? 2'h0 : pd[1:0];
          default: ;
        endcase
      // a write with byte 0 not strobed changes nothing
      pend = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
      pa = s_axi_awaddr;
      pd = s_axi_wdata[7:0];
    end
  end
  always @(negedge aclk) if (aresetn) begin
    chk("wrap_irq", m_flag & m_ctrl[4], wrap_irq);
    chk("irq", m_stat & m_mask, irq);
  end
  task automatic wr(logic [11:0] a, logic [7:0] d);
    bit fa, fw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(fa && fw)) begin
      @(posedge aclk);
      if (s_axi_awready) fa = 1;
      if (s_axi_wready) fw = 1;
      s_axi_awvalid <= !fa;
      s_axi_wvalid <= !fw;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk("bresp", a > 12'h010 ? 2'h2 : 2'h0, s_axi_bresp);
  endtask
  task automatic rd(logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk("rdata", exp_rd, s_axi_rdata);
    chk("rresp", a > 12'h010 ? 2'h2 : 2'h0, s_axi_rresp);
  endtask
  initial begin
    void'($urandom(32'hB1841CF2));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int a = 0; a <= 20; a += 4) rd(a[11:0]);
    wr(12'h004, 8'hFF);
    rd(12'h004);
    s_axi_wstrb <= 4'hE;
    wr(12'h000, 8'h33);
    s_axi_wstrb <= 4'hF;
    rd(12'h000);
    wr(12'h014, 8'h5A);
    for (int s = 0; s < 8; s++) begin
      wr(12'h00C, {7'h0, s[0]});
      wr(12'h004, 8'h00);
      wr(12'h000, 8'hFC | 8'($urandom_range(3)));
      wr(12'h004, {3'h0, s[1], 1'h1, s[2:0]});
      repeat (8 << s) @(posedge aclk);
      wr(12'h004, {3'h0, s[1], 1'h1, s[2:0]});
      rd(12'h000);
      rd(12'h004);
      rd(12'h004);
      rd(12'h008);
      wr(12'h008, 8'h01);
    end
    wr(12'h000, 8'h80);
    wr(12'h010, 8'h02);
    repeat (600) @(posedge aclk);
    rd(12'h000);
    wr(12'h010, 8'h01);
    repeat (600) @(posedge aclk);
    rd(12'h000);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd(12'h000);
    rd(12'h004);
    rd(12'h010);
    wr(12'h010, 8'h03);
    rd(12'h010);
    summarize();
  end
endmodule
